/* tmc_pkg.sv */
// Constants shared by the timer mode, capture and clock-select logic.
// Assumes an 8-bit register port with byte-wide data.
package tmc_pkg;
   // Register offsets
   localparam logic [7:0]  ADDR_CTRL_A  = 8'h80;
   localparam logic [7:0]  ADDR_CTRL_B  = 8'h81;
   localparam logic [7:0]  ADDR_CNT_L   = 8'h84;
   localparam logic [7:0]  ADDR_CNT_H   = 8'h85;
   localparam logic [7:0]  ADDR_ICR_L   = 8'h86;
   localparam logic [7:0]  ADDR_ICR_H   = 8'h87;
   localparam logic [7:0]  ADDR_OCRA_L  = 8'h88;
   localparam logic [7:0]  ADDR_OCRA_H  = 8'h89;
   localparam logic [7:0]  ADDR_FLAGS   = 8'h8F;
   // Reset values
   localparam logic [7:0]  CTRL_B_RESET = 8'h00;
   localparam logic [1:0]  CTRL_A_RESET = 2'h0;
   localparam logic [15:0] WORD_RESET   = 16'h0000;
   // Control B fields
   localparam int          B_FILTER     = 7;
   localparam int          B_EDGE       = 6;
   localparam int          B_RETRIG     = 5;
   localparam int          B_WGM_HI     = 4;
   localparam int          B_WGM_LO     = 3;
   localparam int          B_CS_HI      = 2;
   // Flag register fields
   localparam int          F_OVF        = 0;
   localparam int          F_CAP        = 5;
   // Fixed TOP values and count limits
   localparam logic [15:0] TOP_8BIT     = 16'h00FF;
   localparam logic [15:0] TOP_9BIT     = 16'h01FF;
   localparam logic [15:0] TOP_10BIT    = 16'h03FF;
   localparam logic [15:0] CNT_MAX      = 16'hFFFF;
   localparam logic [15:0] CNT_BOTTOM   = 16'h0000;
   // Prescaler taps: divide by 8, 64, 256, 1024
   localparam logic [9:0]  PRE_MASK8    = 10'h007;
   localparam logic [9:0]  PRE_MASK64   = 10'h03F;
   localparam logic [9:0]  PRE_MASK256  = 10'h0FF;
   localparam logic [9:0]  PRE_MASK1024 = 10'h3FF;
   // Clock select codes
   localparam logic [2:0]  CS_STOP      = 3'h0;
   localparam logic [2:0]  CS_DIV1      = 3'h1;
   localparam logic [2:0]  CS_DIV8      = 3'h2;
   localparam logic [2:0]  CS_DIV64     = 3'h3;
   localparam logic [2:0]  CS_DIV256    = 3'h4;
   localparam logic [2:0]  CS_DIV1024   = 3'h5;
   localparam logic [2:0]  CS_EXT_FALL  = 3'h6;
   localparam logic [2:0]  CS_EXT_RISE  = 3'h7;
   // Capture filter history patterns: four high or four low samples
   localparam logic [3:0]  FILT_ALL1    = 4'hF;
   localparam logic [3:0]  FILT_ALL0    = 4'h0;
   // Count direction for dual-slope modes
   typedef enum logic [1:0] {DIR_UP = 2'b01, DIR_DOWN = 2'b10} tmc_dir_t;
endpackage

/* tmc_capture_filter.sv */
// Capture pin synchroniser, optional four-sample noise filter and edge detector.
// Assumes the pin is asynchronous to mclk.
`timescale 1ns/100ps
module tmc_capture_filter (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic ce,
   // Control
   input  wire logic filterEn,
   input  wire logic risingSel,
   input  wire logic captureEn,
   // Pin and event
   input  wire logic capturePin,
   output logic      captureEvent
);
   logic       sync1;
   logic       sync2;
   logic [3:0] hist;
   logic       filtered;
   logic       prevLevel;
   logic       next_filtered;
   wire        allHigh = hist == tmc_pkg::FILT_ALL1;
   wire        allLow  = hist == tmc_pkg::FILT_ALL0;

   // Unfiltered path also takes one flop so the filter adds exactly four cycles
   assign next_filtered = !filterEn ? sync2 : allHigh ? 1'b1 : allLow ? 1'b0 : filtered;

   always_ff @(posedge mclk) begin
      if (rst) begin
         sync1     <= 1'b0;
         sync2     <= 1'b0;
         hist      <= tmc_pkg::FILT_ALL0;
         filtered  <= 1'b0;
         prevLevel <= 1'b0;
      end else if (ce) begin
         sync1     <= capturePin;
         sync2     <= sync1;
         hist      <= {hist[2:0], sync2};
         filtered  <= next_filtered;
         prevLevel <= filtered;
      end
   end

   assign captureEvent = ce && captureEn &&
                         (risingSel ? (filtered && !prevLevel) : (!filtered && prevLevel));

   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   filt_rise_a: assert property (ce && filterEn && allHigh && !filtered |=> filtered)
      else $error("filter did not follow four high samples");
   filt_hold_a: assert property (ce && filterEn && !allHigh && !allLow |=> $stable(filtered))
      else $error("filter output changed without four agreeing samples");
   edge_sel_a: assert property (captureEvent |-> (filtered == risingSel))
      else $error("capture event on wrong edge");
endmodule

/* tmc_timer.sv */
// Timer mode decoder, control register B, clock select and input capture.
// Assumes a same-clock register port; capture and count pins are asynchronous.
//
// Behaviour
// - Modes 2,3 dual-slope to TOP 0x01FF/0x03FF; compare at TOP, overflow at BOTTOM.
// - Mode 4 clears on compare A; compare immediate; overflow at MAX.
// - Modes 8,9 phase-frequency PWM, TOP capture/compare A; update and overflow at BOTTOM.
// - Mode 12 clears on capture value; compare immediate; overflow at MAX.
// - Control B at 0x81, reset 0x00, fields filter/edge/retrigger/mode/clock.
// - Control B bits 4:3 form mode bits 3:2.
// - Filter output changes only after four agreeing samples.
// - Filter adds four cycles of capture latency.
// - Edge select: zero falling, one rising.
// - Capture edge copies counter to capture register and sets capture flag.
// - Capture disabled while capture register is TOP.
// - Clock code 000 stops timer, 001 counts every I/O clock.
// - External count pin counts even when driven as an output.
// - Codes 010-101 divide by 8/64/256/1024; 110/111 external falling/rising.
// - Control A bits 1:0 form mode bits 1:0.
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps
module tmc_timer (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        ce,
   // Register port
   input  wire logic [7:0]  addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [7:0]  rdata,
   // Pins
   input  wire logic        capturePin,
   input  wire logic        extCountPin,
   // Timer state
   output logic      [15:0] count,
   output logic             overflowFlag,
   output logic             captureFlag
);
   logic [1:0]           ctrlA;
   logic [7:0]           ctrlB;
   logic [15:0]          icr;
   logic [15:0]          ocrA;
   logic [15:0]          ocrABuf;
   logic [9:0]           pre;
   logic                 extSync1;
   logic                 extSync2;
   logic                 extPrev;
   tmc_pkg::tmc_dir_t    dir;
   tmc_pkg::tmc_dir_t    next_dir;
   logic [15:0]          next_count;
   logic [7:0]           next_rdata;
   logic                 captureEvent;

   function automatic logic [15:0] topValue(input logic [3:0] m, input logic [15:0] a, input logic [15:0] c);
      unique case (m)
         4'd1, 4'd5:               topValue = tmc_pkg::TOP_8BIT;
         4'd2, 4'd6:               topValue = tmc_pkg::TOP_9BIT;
         4'd3, 4'd7:               topValue = tmc_pkg::TOP_10BIT;
         4'd4, 4'd9, 4'd11, 4'd15: topValue = a;
         4'd8, 4'd10, 4'd12, 4'd14: topValue = c;
         default:                  topValue = tmc_pkg::CNT_MAX;
      endcase
   endfunction

   function automatic logic clockTick(input logic [2:0] cs, input logic [9:0] p,
                                      input logic rise, input logic fall);
      unique case (cs)
         tmc_pkg::CS_STOP:     clockTick = 1'b0;
         tmc_pkg::CS_DIV1:     clockTick = 1'b1;
         tmc_pkg::CS_DIV8:     clockTick = (p & tmc_pkg::PRE_MASK8) == tmc_pkg::PRE_MASK8;
         tmc_pkg::CS_DIV64:    clockTick = (p & tmc_pkg::PRE_MASK64) == tmc_pkg::PRE_MASK64;
         tmc_pkg::CS_DIV256:   clockTick = (p & tmc_pkg::PRE_MASK256) == tmc_pkg::PRE_MASK256;
         tmc_pkg::CS_DIV1024:  clockTick = p == tmc_pkg::PRE_MASK1024;
         tmc_pkg::CS_EXT_FALL: clockTick = fall;
         tmc_pkg::CS_EXT_RISE: clockTick = rise;
      endcase
   endfunction

   // Mode decode
   wire [3:0]  mode     = {ctrlB[tmc_pkg::B_WGM_HI:tmc_pkg::B_WGM_LO], ctrlA};
   wire        isDual   = (mode >= 4'd1 && mode <= 4'd3) || (mode >= 4'd8 && mode <= 4'd11);
   wire        updImm   = mode == 4'd0 || mode == 4'd4 || mode == 4'd12 || mode == 4'd13;
   wire        updBot   = mode == 4'd8 || mode == 4'd9;
   wire        ovfAtTop = (mode >= 4'd5 && mode <= 4'd7) || mode == 4'd14 || mode == 4'd15;
   wire        topIsIcr = mode == 4'd8 || mode == 4'd10 || mode == 4'd12 || mode == 4'd14;
   wire [15:0] top      = topValue(mode, ocrA, icr);
   wire        atTop    = count == top;
   wire        atBot    = count == tmc_pkg::CNT_BOTTOM;
   wire        goingDn  = dir == tmc_pkg::DIR_DOWN;

   // Clock select; external pin is sampled whatever its port direction
   wire        extRise  = extSync2 && !extPrev;
   wire        extFall  = !extSync2 && extPrev;
   wire        tick     = ce && clockTick(ctrlB[tmc_pkg::B_CS_HI:0], pre, extRise, extFall);

   // Event decode
   wire        bottomHit = tick && isDual && goingDn && atBot;
   wire        topHit    = tick && atTop && !(isDual && goingDn);
   wire        ovfSet    = updImm ? (tick && count == tmc_pkg::CNT_MAX) :
                           ovfAtTop ? topHit : bottomHit;
   wire        ocrLoad   = updImm || (updBot ? bottomHit : topHit);
   wire        capTake   = captureEvent;

   // Register port decode
   wire        wrCtrlA  = wr && addr == tmc_pkg::ADDR_CTRL_A;
   wire        wrCtrlB  = wr && addr == tmc_pkg::ADDR_CTRL_B;
   wire        wrCntL   = wr && addr == tmc_pkg::ADDR_CNT_L;
   wire        wrCntH   = wr && addr == tmc_pkg::ADDR_CNT_H;
   wire        wrIcrL   = wr && addr == tmc_pkg::ADDR_ICR_L;
   wire        wrIcrH   = wr && addr == tmc_pkg::ADDR_ICR_H;
   wire        wrOcrL   = wr && addr == tmc_pkg::ADDR_OCRA_L;
   wire        wrOcrH   = wr && addr == tmc_pkg::ADDR_OCRA_H;
   wire        wrFlags  = wr && addr == tmc_pkg::ADDR_FLAGS;
   wire        clrOvf   = wrFlags && wdata[tmc_pkg::F_OVF];
   wire        clrCap   = wrFlags && wdata[tmc_pkg::F_CAP];
   wire        cntWr    = wrCntL || wrCntH;

   // Counter sequencing
   always_comb begin
      next_count = count;
      next_dir   = tmc_pkg::DIR_UP;
      if (isDual) begin
         next_dir = dir;
         if (!goingDn) begin
            next_count = atTop ? count - 16'h0001 : count + 16'h0001;
            next_dir   = atTop ? tmc_pkg::DIR_DOWN : tmc_pkg::DIR_UP;
         end else begin
            next_count = atBot ? count + 16'h0001 : count - 16'h0001;
            next_dir   = atBot ? tmc_pkg::DIR_UP : tmc_pkg::DIR_DOWN;
         end
      end else begin
         next_count = atTop ? tmc_pkg::CNT_BOTTOM : count + 16'h0001;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         count <= tmc_pkg::WORD_RESET;
         dir   <= tmc_pkg::DIR_UP;
      end else if (ce) begin
         if (wrCntL) begin
            count <= {count[15:8], wdata};
         end else if (wrCntH) begin
            count <= {wdata, count[7:0]};
         end else if (tick) begin
            count <= next_count;
         end
         if (!isDual) begin
            dir <= tmc_pkg::DIR_UP;
         end else if (tick && !cntWr) begin
            dir <= next_dir;
         end
      end
   end

   // Control registers, compare buffer and prescaler
   always_ff @(posedge mclk) begin
      if (rst) begin
         ctrlA   <= tmc_pkg::CTRL_A_RESET;
         ctrlB   <= tmc_pkg::CTRL_B_RESET;
         ocrA    <= tmc_pkg::WORD_RESET;
         ocrABuf <= tmc_pkg::WORD_RESET;
         pre     <= 10'h000;
      end else if (ce) begin
         if (wrCtrlA) begin
            ctrlA <= wdata[1:0];
         end
         if (wrCtrlB) begin
            ctrlB <= wdata;
         end
         if (wrOcrL) begin
            ocrABuf <= {ocrABuf[15:8], wdata};
         end
         if (wrOcrH) begin
            ocrABuf <= {wdata, ocrABuf[7:0]};
         end
         if (ocrLoad) begin
            ocrA <= ocrABuf;
         end
         pre <= pre + 10'h001;
      end
   end

   // External count pin synchroniser
   always_ff @(posedge mclk) begin
      if (rst) begin
         extSync1 <= 1'b0;
         extSync2 <= 1'b0;
         extPrev  <= 1'b0;
      end else if (ce) begin
         extSync1 <= extCountPin;
         extSync2 <= extSync1;
         extPrev  <= extSync2;
      end
   end

   // Capture register and flags; a setting event wins over a clear
   always_ff @(posedge mclk) begin
      if (rst) begin
         icr          <= tmc_pkg::WORD_RESET;
         captureFlag  <= 1'b0;
         overflowFlag <= 1'b0;
      end else if (ce) begin
         if (capTake) begin
            icr <= count;
         end else if (wrIcrL) begin
            icr <= {icr[15:8], wdata};
         end else if (wrIcrH) begin
            icr <= {wdata, icr[7:0]};
         end
         captureFlag  <= capTake || (captureFlag && !clrCap);
         overflowFlag <= ovfSet || (overflowFlag && !clrOvf);
      end
   end

   tmc_capture_filter u_capture (
      .mclk         (mclk),
      .rst          (rst),
      .ce           (ce),
      .filterEn     (ctrlB[tmc_pkg::B_FILTER]),
      .risingSel    (ctrlB[tmc_pkg::B_EDGE]),
      .captureEn    (!topIsIcr),
      .capturePin   (capturePin),
      .captureEvent (captureEvent)
   );

   // Read data, valid only in the cycle after the strobe
   always_comb begin
      unique case (addr)
         tmc_pkg::ADDR_CTRL_A: next_rdata = {6'h00, ctrlA};
         tmc_pkg::ADDR_CTRL_B: next_rdata = ctrlB;
         tmc_pkg::ADDR_CNT_L:  next_rdata = count[7:0];
         tmc_pkg::ADDR_CNT_H:  next_rdata = count[15:8];
         tmc_pkg::ADDR_ICR_L:  next_rdata = icr[7:0];
         tmc_pkg::ADDR_ICR_H:  next_rdata = icr[15:8];
         tmc_pkg::ADDR_OCRA_L: next_rdata = ocrABuf[7:0];
         tmc_pkg::ADDR_OCRA_H: next_rdata = ocrABuf[15:8];
         tmc_pkg::ADDR_FLAGS:  next_rdata = {2'h0, captureFlag, 4'h0, overflowFlag};
         default:              next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         rdata <= 8'h00;
      end else begin
         rdata <= rd ? next_rdata : 8'h00;
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   fixed_top_a: assert property (tick && mode == 4'd2 && count == tmc_pkg::TOP_9BIT && !goingDn && !cntWr
                                 |=> count == 16'h01FE && goingDn)
      else $error("9-bit dual slope did not turn at TOP");
   ctc_clear_a: assert property (tick && mode == 4'd4 && count == ocrA && !cntWr |=> count == 16'h0000)
      else $error("CTC on compare A did not clear");
   fast_ovf_a: assert property (tick && mode == 4'd5 && count == tmc_pkg::TOP_8BIT && !cntWr
                                |=> overflowFlag && count == 16'h0000)
      else $error("8-bit fast PWM wrap or overflow wrong");
   pfc_update_a: assert property (bottomHit && updBot |=> ocrA == $past(ocrABuf) && overflowFlag)
      else $error("phase-frequency update at bottom missed");
   pc_ovf_a: assert property (tick && (mode == 4'd10 || mode == 4'd11) && goingDn && atBot
                              |=> overflowFlag && !goingDn)
      else $error("phase correct bottom overflow missed");
   ctc_icr_a: assert property (tick && mode == 4'd12 && count == icr && !cntWr |=> count == 16'h0000)
      else $error("CTC on capture register did not clear");
   fast_icr_a: assert property (tick && mode == 4'd14 && count == icr && !cntWr |=> count == 16'h0000)
      else $error("fast PWM on capture TOP did not wrap");
   cap_copy_a: assert property (captureEvent |=> captureFlag && icr == $past(count))
      else $error("capture did not copy counter");
   cap_block_a: assert property (topIsIcr && ce |=> !$rose(captureFlag))
      else $error("capture while capture register is TOP");
   clock_stop_a: assert property (ctrlB[2:0] == tmc_pkg::CS_STOP && !cntWr |=> $stable(count))
      else $error("counter moved with clock stopped");

   cap_seen_c: cover property (captureEvent ##1 captureFlag);
   dual_ovf_c: cover property (bottomHit ##1 overflowFlag);
   ext_tick_c: cover property (tick && ctrlB[2:0] == tmc_pkg::CS_EXT_RISE);
endmodule

/* tmc_pin_model.sv */
// Far-side pin model: drives the capture pin and the external count pin.
// Assumes the bench calls its tasks from a process synchronous to mclk.
`timescale 1ns/100ps
module tmc_pin_model (
   // Clock
   input  wire logic mclk,
   // Pins
   output logic      capturePin,
   output logic      extCountPin
);
   initial begin
      capturePin  = 1'b0;
      extCountPin = 1'b0;
   end
   // Level change launched just after an edge
   task automatic setCapture(input logic level);
      @(posedge mclk);
      capturePin <= level;
   endtask
   // High pulse, width in mclk cycles
   task automatic pulseCapture(input int width);
      @(posedge mclk);
      capturePin <= 1'b1;
      repeat (width) @(posedge mclk);
      capturePin <= 1'b0;
   endtask
   // Slow edges so every level survives the synchroniser
   task automatic pulseCount(input int n);
      repeat (n) begin
         @(posedge mclk);
         extCountPin <= 1'b1;
         repeat (6) @(posedge mclk);
         extCountPin <= 1'b0;
         repeat (5) @(posedge mclk);
      end
   endtask
endmodule

/* timer16_mode_capture_clock_bench.sv */
// Self-checking bench for the timer mode, capture and clock-select block.
// Assumes tmc_pkg and the pin model are compiled first.
`timescale 1ns/100ps
module timer16_mode_capture_clock_bench;
   logic        mclk, rst, ce, wr, rd, rdSeen, prevOvf;
   logic [7:0]  addr, wdata, rdata, rnd;
   logic        capturePin, extCountPin, overflowFlag, captureFlag;
   logic [15:0] count, wordV, wordW, delta, top, mx, riseCnt;
   logic [7:0]  expQ [$];
   int          errorCnt, totalChecks, cycleCnt, lat0, lat1, latX;
   int          divTab [6] = '{0, 1, 8, 64, 256, 1024};
   logic [3:0]  modeTab [13] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hE, 4'hF};

   tmc_timer tmc_timer_i (.mclk(mclk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .capturePin(capturePin), .extCountPin(extCountPin), .count(count),
      .overflowFlag(overflowFlag), .captureFlag(captureFlag));
   tmc_pin_model tmc_pin_model_i (.mclk(mclk), .capturePin(capturePin), .extCountPin(extCountPin));

   initial mclk = 1'b0;
   always #2 mclk = ~mclk;

   task automatic fail(input string msg);
      errorCnt++;
      $display("unexpected at %0t: %s", $time, msg);
   endtask
   task automatic compareRead(input logic [7:0] got);
      logic [7:0] exp;
      exp = (expQ.size() > 0) ? expQ.pop_front() : 8'hXX;
      totalChecks++;
      if (got !== exp) fail($sformatf("read %h, expected %h", got, exp));
   endtask
   task automatic checkWord(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
      totalChecks++;
      if (((got >= lo) && (got <= hi)) !== 1'b1) fail($sformatf("value %h outside %h..%h", got, lo, hi));
   endtask
   task automatic checkFlag(input logic got, input logic exp);
      totalChecks++;
      if (got !== exp) fail($sformatf("flag %b, expected %b", got, exp));
   endtask
   task automatic tallyAndFinish();
      $display("checks %0d, mismatches %0d", totalChecks, errorCnt);
      if (errorCnt == 0 && totalChecks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Read data stand only in the cycle after the strobe
   always @(posedge mclk) begin
      if (rdSeen === 1'b1) compareRead(rdata);
      rdSeen <= rd;
   end
   always @(posedge mclk) begin
      cycleCnt++;
      if (cycleCnt == 80000) begin
         fail("run did not finish");
         tallyAndFinish();
      end
   end

   task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task automatic regRead(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      rd   <= 1'b1;
      addr <= a;
      expQ.push_back(e);
      @(posedge mclk);
      rd <= 1'b0;
   endtask
   // No temp latch: low then high byte
   task automatic writeWord(input logic [7:0] a, input logic [15:0] v);
      regWrite(a, v[7:0]);
      regWrite(a + 8'h01, v[15:8]);
   endtask
   task automatic runFor(input int n, output logic [15:0] d);
      logic [15:0] c0;
      @(posedge mclk);
      c0 = count;
      repeat (n) @(posedge mclk);
      d = count - c0;
   endtask
   function automatic logic [15:0] topOf(input logic [3:0] m, input logic [15:0] v);
      case (m)
         4'h5:       topOf = tmc_pkg::TOP_8BIT;
         4'h2, 4'h6: topOf = tmc_pkg::TOP_9BIT;
         4'h3, 4'h7: topOf = tmc_pkg::TOP_10BIT;
         default:    topOf = v;
      endcase
   endfunction
   // Filter gets time to settle on the present level before the pin moves
   task automatic capTry(input logic [7:0] ctrl, input int act, input logic exp, output int lat);
      regWrite(tmc_pkg::ADDR_CTRL_B, ctrl);
      regWrite(tmc_pkg::ADDR_FLAGS, 8'h21);
      repeat (8) @(posedge mclk);
      if (act == 2) tmc_pin_model_i.pulseCapture(3);
      else tmc_pin_model_i.setCapture(act[0]);
      lat = 0;
      while (captureFlag !== 1'b1 && lat < 24) begin
         @(posedge mclk);
         lat++;
      end
      checkFlag(captureFlag, exp);
   endtask

   initial begin
      rst = 1'b1;
      ce = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      rdSeen = 1'b0;
      errorCnt = 0;
      totalChecks = 0;
      cycleCnt = 0;
      void'($urandom(4));
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      regRead(tmc_pkg::ADDR_CTRL_B, 8'h00);
      rnd = 8'($urandom()) & 8'hDF;
      regWrite(tmc_pkg::ADDR_CTRL_B, rnd);
      regWrite(8'h83, ~rnd);
      regRead(tmc_pkg::ADDR_CTRL_B, rnd);
      regRead(8'h83, 8'h00);
      regWrite(tmc_pkg::ADDR_CTRL_B, 8'h00);
      writeWord(tmc_pkg::ADDR_CNT_L, 16'h0000);
      // Any window of k*div cycles holds exactly k prescaler ticks
      for (int i = 0; i < 6; i++) begin
         regWrite(tmc_pkg::ADDR_CTRL_B, {5'h00, 3'(i)});
         runFor((i == 0) ? 64 : 8 * divTab[i], delta);
         checkWord(delta, (i == 0) ? 16'h0000 : 16'h0008, (i == 0) ? 16'h0000 : 16'h0008);
      end
      regWrite(tmc_pkg::ADDR_CTRL_B, {5'h00, tmc_pkg::CS_DIV1});
      ce <= 1'b0;
      runFor(20, delta);
      checkWord(delta, 16'h0000, 16'h0000);
      ce <= 1'b1;
      for (int i = 6; i < 8; i++) begin
         regWrite(tmc_pkg::ADDR_CTRL_B, {5'h00, 3'(i)});
         @(posedge mclk);
         wordW = count;
         tmc_pin_model_i.pulseCount(5);
         repeat (8) @(posedge mclk);
         checkWord(count - wordW, 16'h0005, 16'h0005);
      end
      wordV = 16'h0080 + 16'($urandom_range(255));
      writeWord(tmc_pkg::ADDR_OCRA_L, wordV);
      writeWord(tmc_pkg::ADDR_ICR_L, wordV);
      regRead(tmc_pkg::ADDR_OCRA_H, wordV[15:8]);
      // Mode 13 left out on purpose
      for (int i = 0; i < 13; i++) begin
         top = topOf(modeTab[i], wordV);
         regWrite(tmc_pkg::ADDR_CTRL_B, 8'h00);
         writeWord(tmc_pkg::ADDR_CNT_L, 16'h0000);
         regWrite(tmc_pkg::ADDR_CTRL_A, {6'h00, modeTab[i][1:0]});
         regWrite(tmc_pkg::ADDR_CTRL_B, {3'h0, modeTab[i][3:2], tmc_pkg::CS_DIV1});
         repeat (2 * top + 8) @(posedge mclk);
         regWrite(tmc_pkg::ADDR_FLAGS, 8'h21);
         mx = 16'h0000;
         riseCnt = 16'hFFFF;
         prevOvf = overflowFlag;
         repeat (2 * top + 8) begin
            @(posedge mclk);
            if (count > mx) mx = count;
            if (overflowFlag === 1'b1 && prevOvf !== 1'b1 && riseCnt === 16'hFFFF) riseCnt = count;
            prevOvf = overflowFlag;
         end
         checkWord(mx, top, top);
         if (modeTab[i] == 4'h4 || modeTab[i] == 4'hC)
            checkFlag(overflowFlag, 1'b0);
         else if (modeTab[i] inside {4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB})
            checkWord(riseCnt, 16'h0001, 16'h0001);
         else
            checkWord(riseCnt, 16'h0000, 16'h0000);
      end
      regWrite(tmc_pkg::ADDR_CTRL_B, 8'h00);
      regWrite(tmc_pkg::ADDR_CTRL_A, 8'h00);
      wordW = 16'($urandom());
      writeWord(tmc_pkg::ADDR_CNT_L, wordW);
      capTry(8'h40, 1, 1'b1, lat0);
      regRead(tmc_pkg::ADDR_ICR_L, wordW[7:0]);
      regRead(tmc_pkg::ADDR_ICR_H, wordW[15:8]);
      capTry(8'h40, 0, 1'b0, latX);
      capTry(8'h00, 1, 1'b0, latX);
      capTry(8'h00, 0, 1'b1, latX);
      capTry(8'hC0, 1, 1'b1, lat1);
      checkWord(16'(lat1 - lat0), 16'h0004, 16'h0004);
      capTry(8'hC0, 0, 1'b0, latX);
      capTry(8'hC0, 2, 1'b0, latX);
      capTry(8'h40, 2, 1'b1, latX);
      regWrite(tmc_pkg::ADDR_CTRL_A, 8'h02);
      capTry(8'h58, 1, 1'b0, latX);
      repeat (4) @(posedge mclk);
      tallyAndFinish();
   end
endmodule
